// [src/dcil_pkg.sv]
package dcil_pkg;

  // Pin and array geometry
  localparam int ADDR_W     = 14;
  localparam int ROW_W      = 17;
  localparam int COL_W      = 10;
  localparam int BANK_W     = 3;
  localparam int BA_W       = 2;
  localparam int BANKS      = 8;
  localparam int LAT_W      = 5;
  localparam int BEAT_W     = 4;
  localparam int ORDER_W    = 24;
  localparam int TERM_LINES = 20;
  localparam int PIN_W      = 24;

  // Address bits with a second meaning
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // Refresh pacing kept internally while self-refreshing
  localparam int SREF_INT_NS  = 7800;
  localparam int CLK_NS       = 40;
  localparam int SREF_INT_CYC = SREF_INT_NS / CLK_NS;
  localparam logic [7:0] SREF_CNT_MAX = 8'(SREF_INT_CYC - 1);

  localparam logic [BEAT_W-1:0] BEATS_FULL = 4'h8;
  localparam logic [BEAT_W-1:0] BEATS_CHOP = 4'h4;
  localparam logic [LAT_W-1:0]  LAT_ONE    = 5'h01;
  localparam logic [LAT_W-1:0]  LAT_TWO    = 5'h02;

  // Chip select, activate and the three shared pins form the code
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_RFU = 4'h3,
    CMD_WR  = 4'h4,
    CMD_RD  = 4'h5,
    CMD_ZQ  = 4'h6,
    CMD_NOP = 4'h7,
    CMD_ACT = 4'h8,
    CMD_DES = 4'hF
  } dcil_cmd_t;

  typedef enum logic [1:0] {
    PS_RUN  = 2'h0,
    PS_PPD  = 2'h1,
    PS_SREF = 2'h3,
    PS_APD  = 2'h2
  } dcil_pstate_t;

  typedef enum logic [1:0] {
    BM_FIX8 = 2'h0,
    BM_OTF  = 2'h1,
    BM_FIX4 = 2'h2
  } dcil_bmode_t;

  typedef enum logic [1:0] {
    AL_ZERO = 2'h0,
    AL_CLM1 = 2'h1,
    AL_CLM2 = 2'h2
  } dcil_alsel_t;

  // Command code from the sampled control pins
  function automatic dcil_cmd_t dcil_decode(logic cs_n, logic act_n, logic [2:0] rcw);
    if (cs_n)
      return CMD_DES;
    else if (!act_n)
      return CMD_ACT;
    else
      return dcil_cmd_t'({1'b0, rcw});
  endfunction

  function automatic logic dcil_is_rw(dcil_cmd_t c);
    return (c == CMD_RD) || (c == CMD_WR);
  endfunction

endpackage

// [src/dcil_cmd_if.sv]
`timescale 1ns/10ps
interface dcil_cmd_if;
  import dcil_pkg::*;
  logic              valid;
  dcil_cmd_t         cmd;
  logic [BANK_W-1:0] bank;
  logic              auto_close;
  logic [BANKS-1:0]  open;

  modport decoder (output valid, output cmd, output bank, output auto_close, input open);
  modport tracker (input valid, input cmd, input bank, input auto_close, output open);
endinterface

// [src/dcil_sync.sv]
`timescale 1ns/10ps
module dcil_sync
  import dcil_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Second stage is the only reader of the first
  always_comb
  begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // Pins taken on the rising crossing of the clock pair
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      q_r    <= '0;
    end
    else
    begin
      meta_r <= meta_nxt; // R01
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// [src/dcil_banks.sv]
`timescale 1ns/10ps
module dcil_banks
  import dcil_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   resetn,
  dcil_cmd_if.tracker cif
);

  logic [BANKS-1:0] open_r;
  logic [BANKS-1:0] open_nxt;

  // Row open per bank, indexed by group and bank select
  always_comb
  begin
    open_nxt = open_r;
    if (cif.valid)
    begin
      unique case (cif.cmd)
        CMD_ACT: open_nxt[cif.bank] = 1'b1; // R12
        CMD_PRE:
        begin
          if (cif.auto_close)
            open_nxt = '0; // R20
          else
            open_nxt[cif.bank] = 1'b0; // R20
        end
        CMD_RD, CMD_WR:
        begin
          // Closing at the command keeps the map simple; the data path owns timing
          if (cif.auto_close)
            open_nxt[cif.bank] = 1'b0; // R19
        end
        default: open_nxt = open_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      open_r <= '0;
    else
      open_r <= open_nxt;
  end

  assign cif.open = open_r;

  property p_act_opens;
    @(posedge clk) disable iff (!resetn)
    (cif.valid && cif.cmd == CMD_ACT) |=> open_r[$past(cif.bank)];
  endproperty
  a_act_opens: assert property (p_act_opens) else $error("activate left bank closed"); // R12

  property p_rw_close;
    @(posedge clk) disable iff (!resetn)
    (cif.valid && dcil_is_rw(cif.cmd)) |=> (open_r[$past(cif.bank)] != $past(cif.auto_close))
      || !$past(open_r[cif.bank]) && !$past(cif.auto_close);
  endproperty
  a_rw_close: assert property (p_rw_close) else $error("auto close bit not honoured"); // R19

  property p_pre_all;
    @(posedge clk) disable iff (!resetn)
    (cif.valid && cif.cmd == CMD_PRE && cif.auto_close) |=> (open_r == '0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open"); // R20

  property p_pre_one;
    @(posedge clk) disable iff (!resetn)
    (cif.valid && cif.cmd == CMD_PRE && !cif.auto_close) |=> !open_r[$past(cif.bank)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("single precharge missed its bank"); // R20

endmodule

// [src/dcil_front.sv]
`timescale 1ns/10ps
// Functional notes
// R01 - Sample control and address on clock rising crossing
// R02 - Clock gate high runs clocks, buffers, drivers
// R03 - Gate low: precharge/self-refresh idle, active power-down open
// R04 - Self-refresh exit on clock gate alone
// R05 - Controller keeps clock gate high during accesses
// R06 - Power-down keeps only clock, termination, gate buffers
// R07 - Self-refresh keeps only the clock gate buffer
// R08 - Chip select high masks the command
// R09 - Chip select is one bit of command code
// R10 - Termination input high applies nominal termination everywhere
// R11 - Termination input ignored when mode register disables
// R12 - Eight banks, two groups of four, addressed
// R13 - Added latency zero, read latency less one, two
// R14 - Controller refreshes 8192 times per 64 ms
// R15 - Hot range doubles refresh rate, 32 ms window
// R16 - Fixed eight, fixed chopped four, or per command
// R17 - Sequential or interleaved burst column order
// R18 - Activate low turns shared pins into row bits
// R19 - Auto close bit high precharges after access
// R20 - Precharge: one bank, or all with bit high
// R21 - On the fly: chop bit high full, low chopped
// R22 - Self-refresh refreshes internally and ignores commands
// R23 - Controller enters self-refresh only with banks idle
module dcil_front
  import dcil_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  cke,
  input  wire logic                  cs_n,
  input  wire logic                  activate_n,
  input  wire logic                  ras_a16,
  input  wire logic                  cas_a15,
  input  wire logic                  we_a14,
  input  wire logic                  bg,
  input  wire logic [BA_W-1:0]       ba,
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic                  termination_control_in,
  input  wire logic                  nominal_termination_en,
  input  wire logic [1:0]            burst_mode,
  input  wire logic                  burst_interleave,
  input  wire logic [1:0]            added_latency_sel,
  input  wire logic [LAT_W-1:0]      read_latency,
  output logic                       clk_run,
  output logic                       cmd_buf_en,
  output logic                       clk_buf_en,
  output logic                       term_buf_en,
  output logic                       out_drv_en,
  output logic [1:0]                 power_state,
  output logic                       cmd_valid,
  output logic [3:0]                 cmd_code,
  output logic [BANK_W-1:0]          cmd_bank,
  output logic [ROW_W-1:0]           row_addr,
  output logic [COL_W-1:0]           col_addr,
  output logic                       auto_close,
  output logic [BEAT_W-1:0]          burst_beats,
  output logic [ORDER_W-1:0]         burst_order,
  output logic [LAT_W-1:0]           added_latency,
  output logic [TERM_LINES-1:0]      term_apply,
  output logic [BANKS-1:0]           banks_open,
  output logic                       sref_refresh
);

  // Column index for each beat, beat zero in the low bits
  function automatic logic [ORDER_W-1:0] burst_cols(logic [2:0] s, logic il);
    logic [ORDER_W-1:0] o;
    logic [2:0]         b;
    o = '0;
    for (int i = 0; i < 8; i++)
    begin
      b = 3'(i);
      o[i*3 +: 3] = il ? (s ^ b) : 3'(s + b); // R17
    end
    return o;
  endfunction

  // Added latency relative to the read latency
  function automatic logic [LAT_W-1:0] al_value(logic [1:0] sel, logic [LAT_W-1:0] cl);
    unique case (dcil_alsel_t'(sel))
      AL_CLM1: return 5'(cl - LAT_ONE); // R13
      AL_CLM2: return 5'(cl - LAT_TWO); // R13
      default: return '0;
    endcase
  endfunction

  logic [PIN_W-1:0]  pins_s;
  logic              cke_s;
  logic              cs_n_s;
  logic              act_n_s;
  logic [2:0]        rcw_s;
  logic              odt_s;
  logic [BANK_W-1:0] bank_s;
  logic [ADDR_W-1:0] addr_s;
  dcil_cmd_t         dec_cmd;

  // Every pin passes two flops before any decode sees it
  dcil_sync #(.W(PIN_W)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({cke, cs_n, activate_n, ras_a16, cas_a15, we_a14, termination_control_in, bg, ba, addr}),
    .q      (pins_s)
  );

  assign {cke_s, cs_n_s, act_n_s, rcw_s, odt_s, bank_s, addr_s} = pins_s; // R12
  assign dec_cmd = dcil_decode(cs_n_s, act_n_s, rcw_s); // R09

  dcil_cmd_if cif ();

  dcil_banks u_banks (
    .clk    (clk),
    .resetn (resetn),
    .cif    (cif)
  );

  dcil_pstate_t state_r;
  dcil_pstate_t state_nxt;
  logic         cke_prev_r;
  logic         take;

  // Commands count only on a steady high gate with buffers live
  assign take = (state_r == PS_RUN) && cke_s && cke_prev_r && !cs_n_s; // R05 R08

  // Power state from the gate level and the bank map
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PS_RUN:
      begin
        if (cke_prev_r && !cke_s)
        begin
          // Entry does not check banks; the controller guarantees idle
          if (dec_cmd == CMD_REF)
            state_nxt = PS_SREF; // R03 R23
          else if (cif.open != '0)
            state_nxt = PS_APD; // R03
          else
            state_nxt = PS_PPD; // R03
        end
      end
      PS_PPD, PS_APD:
      begin
        if (cke_s)
          state_nxt = PS_RUN; // R02
      end
      PS_SREF:
      begin
        // Gate level alone ends it; no command decode in the path
        if (cke_s)
          state_nxt = PS_RUN; // R04
      end
    endcase
  end

  logic clk_run_r;
  logic cmd_buf_r;
  logic clk_buf_r;
  logic term_buf_r;
  logic drv_r;
  logic clk_run_nxt;
  logic cmd_buf_nxt;
  logic clk_buf_nxt;
  logic term_buf_nxt;
  logic drv_nxt;

  // Buffer and clock gating follow the next power state
  always_comb
  begin
    clk_run_nxt  = (state_nxt == PS_RUN); // R02
    cmd_buf_nxt  = (state_nxt == PS_RUN); // R06 R07
    drv_nxt      = (state_nxt == PS_RUN); // R02
    clk_buf_nxt  = (state_nxt != PS_SREF); // R06 R07
    term_buf_nxt = (state_nxt != PS_SREF); // R06 R07
  end

  logic                  valid_r;
  logic                  valid_nxt;
  dcil_cmd_t             code_r;
  dcil_cmd_t             code_nxt;
  logic [BANK_W-1:0]     bank_r;
  logic [BANK_W-1:0]     bank_nxt;
  logic [ROW_W-1:0]      row_r;
  logic [ROW_W-1:0]      row_nxt;
  logic [COL_W-1:0]      col_r;
  logic [COL_W-1:0]      col_nxt;
  logic                  ac_r;
  logic                  ac_nxt;
  logic [BEAT_W-1:0]     beats_r;
  logic [BEAT_W-1:0]     beats_nxt;
  logic [ORDER_W-1:0]    order_r;
  logic [ORDER_W-1:0]    order_nxt;
  logic [LAT_W-1:0]      al_r;
  logic [LAT_W-1:0]      al_nxt;
  logic [TERM_LINES-1:0] term_r;
  logic [TERM_LINES-1:0] term_nxt;
  logic [7:0]            sref_cnt_r;
  logic [7:0]            sref_cnt_nxt;
  logic                  sref_pulse_r;
  logic                  sref_pulse_nxt;

  // Command capture; address fields hold their last value otherwise
  always_comb
  begin
    valid_nxt = take; // R08 R22
    code_nxt  = take ? dec_cmd : CMD_DES;
    bank_nxt  = take ? bank_s : bank_r;
    row_nxt   = row_r;
    col_nxt   = col_r;
    ac_nxt    = ac_r;
    beats_nxt = beats_r;
    order_nxt = order_r;
    if (take && dec_cmd == CMD_ACT)
      row_nxt = {rcw_s, addr_s}; // R18
    if (take && (dec_cmd == CMD_PRE || dcil_is_rw(dec_cmd)))
      ac_nxt = addr_s[AP_BIT]; // R19 R20
    if (take && dcil_is_rw(dec_cmd))
    begin
      col_nxt   = addr_s[COL_W-1:0];
      order_nxt = burst_cols(addr_s[2:0], burst_interleave); // R17
      unique case (dcil_bmode_t'(burst_mode))
        BM_FIX4: beats_nxt = BEATS_CHOP; // R16
        BM_OTF:  beats_nxt = addr_s[BC_BIT] ? BEATS_FULL : BEATS_CHOP; // R21
        default: beats_nxt = BEATS_FULL; // R16
      endcase
    end
    al_nxt = al_value(added_latency_sel, read_latency); // R13
    // Termination pin is dead when its buffer is off or nominal_termination_en is low
    term_nxt = {TERM_LINES{odt_s && nominal_termination_en && (state_nxt != PS_SREF)}}; // R10 R11
  end

  // Internal refresh pacing while the gate is low in self-refresh
  always_comb
  begin
    sref_cnt_nxt   = '0;
    sref_pulse_nxt = 1'b0;
    if (state_r == PS_SREF)
    begin
      sref_pulse_nxt = (sref_cnt_r == SREF_CNT_MAX); // R22
      sref_cnt_nxt   = sref_pulse_nxt ? '0 : 8'(sref_cnt_r + 8'h01);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r      <= PS_RUN;
      cke_prev_r   <= 1'b0;
      clk_run_r    <= 1'b0;
      cmd_buf_r    <= 1'b0;
      clk_buf_r    <= 1'b0;
      term_buf_r   <= 1'b0;
      drv_r        <= 1'b0;
      valid_r      <= 1'b0;
      code_r       <= CMD_DES;
      bank_r       <= '0;
      row_r        <= '0;
      col_r        <= '0;
      ac_r         <= 1'b0;
      beats_r      <= BEATS_FULL;
      order_r      <= '0;
      al_r         <= '0;
      term_r       <= '0;
      sref_cnt_r   <= '0;
      sref_pulse_r <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      cke_prev_r   <= cke_s;
      clk_run_r    <= clk_run_nxt;
      cmd_buf_r    <= cmd_buf_nxt;
      clk_buf_r    <= clk_buf_nxt;
      term_buf_r   <= term_buf_nxt;
      drv_r        <= drv_nxt;
      valid_r      <= valid_nxt;
      code_r       <= code_nxt;
      bank_r       <= bank_nxt;
      row_r        <= row_nxt;
      col_r        <= col_nxt;
      ac_r         <= ac_nxt;
      beats_r      <= beats_nxt;
      order_r      <= order_nxt;
      al_r         <= al_nxt;
      term_r       <= term_nxt;
      sref_cnt_r   <= sref_cnt_nxt;
      sref_pulse_r <= sref_pulse_nxt;
    end
  end

  // Bank tracker sees the registered command
  assign cif.valid      = valid_r;
  assign cif.cmd        = code_r;
  assign cif.bank       = bank_r;
  assign cif.auto_close = ac_r;

  assign clk_run       = clk_run_r;
  assign cmd_buf_en    = cmd_buf_r;
  assign clk_buf_en    = clk_buf_r;
  assign term_buf_en   = term_buf_r;
  assign out_drv_en    = drv_r;
  assign power_state   = state_r;
  assign cmd_valid     = valid_r;
  assign cmd_code      = code_r;
  assign cmd_bank      = bank_r;
  assign row_addr      = row_r;
  assign col_addr      = col_r;
  assign auto_close    = ac_r;
  assign burst_beats   = beats_r;
  assign burst_order   = order_r;
  assign added_latency = al_r;
  assign term_apply    = term_r;
  assign banks_open    = cif.open;
  assign sref_refresh  = sref_pulse_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_sref_entry;
    (state_r == PS_RUN) && cke_prev_r && !cke_s && (dec_cmd == CMD_REF);
  endsequence

  sequence s_pd_entry;
    (state_r == PS_RUN) && cke_prev_r && !cke_s && (dec_cmd != CMD_REF);
  endsequence

  property p_masked;
    cs_n_s |=> !valid_r;
  endproperty
  a_masked: assert property (p_masked) else $error("command taken with chip select high"); // R08

  property p_code;
    (valid_r && code_r == CMD_ACT) |-> $past(!cs_n_s && !act_n_s);
  endproperty
  a_code: assert property (p_code) else $error("activate decoded without its pins"); // R09

  property p_gate_rise;
    (cke_s && !cke_prev_r && state_r != PS_RUN) |=> clk_run_r && drv_r && cmd_buf_r;
  endproperty
  a_gate_rise: assert property (p_gate_rise) else $error("clocks not restarted"); // R02

  property p_pd_kind;
    s_pd_entry |=> (state_r == ($past(cif.open) != '0 ? PS_APD : PS_PPD)) && !clk_run_r;
  endproperty
  a_pd_kind: assert property (p_pd_kind) else $error("wrong power-down kind"); // R03

  property p_sref_exit;
    s_sref_entry ##1 (!cke_s)[*2] ##1 cke_s |=> (state_r == PS_RUN);
  endproperty
  a_sref_exit: assert property (p_sref_exit) else $error("self-refresh exit missed"); // R04

  property p_pd_bufs;
    (state_r == PS_PPD || state_r == PS_APD) |-> clk_buf_r && term_buf_r && !cmd_buf_r && !drv_r;
  endproperty
  a_pd_bufs: assert property (p_pd_bufs) else $error("power-down buffer set wrong"); // R06

  property p_sref_bufs;
    s_sref_entry |=> (!clk_buf_r && !term_buf_r && !cmd_buf_r)[*2];
  endproperty
  a_sref_bufs: assert property (p_sref_bufs) else $error("self-refresh buffer set wrong"); // R07

  property p_term_on;
    (odt_s && nominal_termination_en && state_nxt != PS_SREF) |=> (term_r == '1);
  endproperty
  a_term_on: assert property (p_term_on) else $error("termination not applied"); // R10

  property p_term_off;
    !nominal_termination_en |=> (term_r == '0);
  endproperty
  a_term_off: assert property (p_term_off) else $error("termination pin not ignored"); // R11

  property p_al;
    (added_latency_sel == AL_CLM2) |=> (al_r == 5'($past(read_latency) - LAT_TWO));
  endproperty
  a_al: assert property (p_al) else $error("added latency wrong"); // R13

  property p_chop_fixed;
    (valid_r && dcil_is_rw(code_r) && $past(burst_mode) == BM_FIX4) |-> (beats_r == BEATS_CHOP);
  endproperty
  a_chop_fixed: assert property (p_chop_fixed) else $error("fixed chop ignored"); // R16

  property p_otf;
    (take && dcil_is_rw(dec_cmd) && burst_mode == BM_OTF)
      |=> (beats_r == ($past(addr_s[BC_BIT]) ? BEATS_FULL : BEATS_CHOP));
  endproperty
  a_otf: assert property (p_otf) else $error("chop bit not honoured"); // R21

  property p_interleave;
    (valid_r && dcil_is_rw(code_r) && $past(burst_interleave)) |-> (order_r[5:3] == (col_r[2:0] ^ 3'h1));
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave order wrong"); // R17

  property p_sref_quiet;
    s_sref_entry |=> (!valid_r && state_r == PS_SREF) ##1 (sref_cnt_r == 8'h01);
  endproperty
  a_sref_quiet: assert property (p_sref_quiet) else $error("self-refresh not quiet"); // R22

endmodule

// [tb/dcil_ctrl_model.sv]
`timescale 1ns/10ps
module dcil_ctrl_model
  import dcil_pkg::*;
(
  input  wire logic          clk,
  output logic               cke,
  output logic               cs_n,
  output logic               activate_n,
  output logic               ras_a16,
  output logic               cas_a15,
  output logic               we_a14,
  output logic               bg,
  output logic [BA_W-1:0]    ba,
  output logic [ADDR_W-1:0]  addr,
  output logic               termination_control_in
);
  // Deselected pins, gate high so reset exit needs no wake-up
  initial
  begin
    cke = 1'b1;
    cs_n = 1'b1;
    activate_n = 1'b1;
    {ras_a16, cas_a15, we_a14} = 3'h7;
    {bg, ba} = 3'h0;
    addr = '0;
    termination_control_in = 1'b0;
  end

  // Gate and termination levels, moved off the sampling edge
  task automatic level(input logic gate, input logic term);
    @(negedge clk);
    cke = gate;
    termination_control_in = term;
  endtask

  // One command slot; stale lines then carry the inverse so old values never pass
  task automatic issue(input logic cs, input logic act, input logic [2:0] rcw, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] ad, input logic gate);
    @(negedge clk);
    cs_n = cs;
    activate_n = act;
    {ras_a16, cas_a15, we_a14} = rcw;
    {bg, ba} = b;
    addr = ad;
    cke = gate;
    @(negedge clk);
    cs_n = 1'b1;
    activate_n = ~act;
    {ras_a16, cas_a15, we_a14} = ~rcw;
    {bg, ba} = ~b;
    addr = ~ad;
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench
  import dcil_pkg::*;
;
  logic                clk, resetn, cke, cs_n, activate_n, ras_a16, cas_a15, we_a14, bg;
  logic [BA_W-1:0]     ba;
  logic [ADDR_W-1:0]   addr, a;
  logic                termination_control_in, nominal_termination_en, burst_interleave;
  logic [1:0]          burst_mode, added_latency_sel, power_state;
  logic [LAT_W-1:0]    read_latency, added_latency;
  logic                clk_run, cmd_buf_en, clk_buf_en, term_buf_en, out_drv_en, cmd_valid;
  logic [3:0]          cmd_code;
  logic [BANK_W-1:0]   cmd_bank, bk;
  logic [ROW_W-1:0]    row_addr, row;
  logic [COL_W-1:0]    col_addr;
  logic                auto_close, sref_refresh;
  logic [BEAT_W-1:0]   burst_beats;
  logic [ORDER_W-1:0]  burst_order;
  logic [TERM_LINES-1:0] term_apply;
  logic [BANKS-1:0]    banks_open, om;
  logic [2:0]          codes [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  int                  n_errors, check_count, n;

  dcil_ctrl_model u_dcil_ctrl_model (.clk(clk), .cke(cke), .cs_n(cs_n), .activate_n(activate_n),
    .ras_a16(ras_a16), .cas_a15(cas_a15), .we_a14(we_a14), .bg(bg), .ba(ba), .addr(addr),
    .termination_control_in(termination_control_in));

  dcil_front u_dcil_front (.*);

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Command slot, then sample while the one-cycle result stands
  task automatic run(input logic cs, input logic act, input logic [2:0] rcw, input logic [BANK_W-1:0] b,
                     input logic [ADDR_W-1:0] ad, input logic gate);
    u_dcil_ctrl_model.issue(cs, act, rcw, b, ad, gate);
    repeat (2) @(negedge clk);
  endtask

  // Bounded wait for a power state; running out ends the run
  task automatic wait_ps(input logic [1:0] ps);
    for (int i = 0; i < 20 && power_state !== ps; i++)
      @(negedge clk);
    if (power_state !== ps)
    begin
      chk("power_state", 32'(ps), 32'(power_state));
      finish_test();
    end
  endtask

  function automatic logic [ORDER_W-1:0] exp_order(input logic [2:0] s, input logic il);
    logic [ORDER_W-1:0] o;
    o = '0;
    for (int i = 0; i < 8; i++)
      o[3*i +: 3] = il ? (s ^ 3'(i)) : (s + 3'(i));
    return o;
  endfunction

  function automatic logic [BEAT_W-1:0] exp_beats(input logic [1:0] m, input logic a12);
    if (m == 2'h1)
      return a12 ? 4'h8 : 4'h4;
    return (m == 2'h2) ? 4'h4 : 4'h8;
  endfunction

  function automatic logic [LAT_W-1:0] exp_al(input logic [1:0] s, input logic [LAT_W-1:0] r);
    if (s == 2'h1)
      return r - 5'h01;
    return (s == 2'h2) ? r - 5'h02 : 5'h00;
  endfunction

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    nominal_termination_en = 1'b1;
    burst_mode = 2'h0;
    burst_interleave = 1'b0;
    added_latency_sel = 2'h0;
    read_latency = 5'h10;
    n_errors = 0;
    check_count = 0;
    om = '0;
    void'($urandom(32'h8177));
    repeat (8) @(negedge clk);
    chk("cmd_code", 32'hF, 32'(cmd_code));
    chk("burst_beats", 32'h8, 32'(burst_beats));
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    // Activates to random banks and rows
    for (int i = 0; i < 6; i++)
    begin
      bk = BANK_W'($urandom);
      row = ROW_W'($urandom);
      run(1'b0, 1'b0, row[16:14], bk, row[13:0], 1'b1);
      chk("cmd_valid", 32'h1, 32'(cmd_valid));
      chk("cmd_code", 32'h8, 32'(cmd_code));
      chk("cmd_bank", 32'(bk), 32'(cmd_bank));
      chk("row_addr", 32'(row), 32'(row_addr));
      om[bk] = 1'b1;
      @(negedge clk);
      chk("cmd_valid", 32'h0, 32'(cmd_valid));
      chk("banks_open", 32'(om), 32'(banks_open));
    end
    $display("test activate done");
    // Deselected slot, then plain codes 0, 1, 4, 5 and 6
    run(1'b1, 1'b0, 3'h0, 3'h7, 14'h0, 1'b1);
    chk("cmd_valid", 32'h0, 32'(cmd_valid));
    foreach (codes[k])
    begin
      run(1'b0, 1'b1, codes[k], 3'h0, 14'h0, 1'b1);
      chk("cmd_code", 32'(codes[k]), 32'(cmd_code));
    end
    chk("banks_open", 32'(om), 32'(banks_open));
    $display("test codes done");
    // Every burst mode, chop bit and column order
    for (int m = 0; m < 3; m++)
      for (int j = 0; j < 4; j++)
      begin
        burst_mode = 2'(m);
        burst_interleave = j[0];
        a = ADDR_W'($urandom);
        a[AP_BIT] = 1'b0;
        a[BC_BIT] = j[1];
        run(1'b0, 1'b1, 3'h5, 3'h0, a, 1'b1);
        chk("col_addr", 32'(a[COL_W-1:0]), 32'(col_addr));
        chk("burst_beats", 32'(exp_beats(2'(m), j[1])), 32'(burst_beats));
        chk("burst_order", 32'(exp_order(a[2:0], j[0])), 32'(burst_order));
      end
    $display("test burst done");
    // Auto close, single precharge, precharge all
    run(1'b0, 1'b0, 3'h0, 3'h3, 14'h0, 1'b1);
    run(1'b0, 1'b0, 3'h0, 3'h6, 14'h0, 1'b1);
    om[6] = 1'b1;
    run(1'b0, 1'b1, 3'h4, 3'h3, 14'h0400, 1'b1);
    chk("auto_close", 32'h1, 32'(auto_close));
    om[3] = 1'b0;
    @(negedge clk);
    chk("banks_open", 32'(om), 32'(banks_open));
    run(1'b0, 1'b1, 3'h2, 3'h6, 14'h0, 1'b1);
    om[6] = 1'b0;
    @(negedge clk);
    chk("banks_open", 32'(om), 32'(banks_open));
    run(1'b0, 1'b1, 3'h2, 3'h0, 14'h0400, 1'b1);
    @(negedge clk);
    chk("banks_open", 32'h0, 32'(banks_open));
    // Precharge and active power-down
    u_dcil_ctrl_model.level(1'b0, 1'b0);
    wait_ps(PS_PPD);
    chk("clk_run", 32'h0, 32'(clk_run));
    chk("out_drv_en", 32'h0, 32'(out_drv_en));
    chk("cmd_buf_en", 32'h0, 32'(cmd_buf_en));
    chk("clk_buf_en", 32'h1, 32'(clk_buf_en));
    chk("term_buf_en", 32'h1, 32'(term_buf_en));
    run(1'b0, 1'b0, 3'h0, 3'h2, 14'h0, 1'b0);
    chk("cmd_valid", 32'h0, 32'(cmd_valid));
    u_dcil_ctrl_model.level(1'b1, 1'b0);
    wait_ps(PS_RUN);
    chk("out_drv_en", 32'h1, 32'(out_drv_en));
    run(1'b0, 1'b0, 3'h0, 3'h5, 14'h0, 1'b1);
    u_dcil_ctrl_model.level(1'b0, 1'b0);
    wait_ps(PS_APD);
    u_dcil_ctrl_model.level(1'b1, 1'b0);
    wait_ps(PS_RUN);
    $display("test power-down done");
    // Termination follows pin and enable
    u_dcil_ctrl_model.level(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    chk("term_apply", 32'hFFFFF, 32'(term_apply));
    nominal_termination_en = 1'b0;
    repeat (2) @(negedge clk);
    chk("term_apply", 32'h0, 32'(term_apply));
    nominal_termination_en = 1'b1;
    // Added latency for every selector value
    for (int s = 0; s < 4; s++)
    begin
      added_latency_sel = 2'(s);
      read_latency = LAT_W'(2 + $urandom_range(29));
      repeat (2) @(negedge clk);
      chk("added_latency", 32'(exp_al(2'(s), read_latency)), 32'(added_latency));
    end
    // Self-refresh entered after a precharge all closes every bank
    run(1'b0, 1'b1, 3'h2, 3'h0, 14'h0400, 1'b1);
    run(1'b0, 1'b1, 3'h1, 3'h0, 14'h0, 1'b0);
    wait_ps(PS_SREF);
    chk("clk_buf_en", 32'h0, 32'(clk_buf_en));
    chk("term_buf_en", 32'h0, 32'(term_buf_en));
    chk("term_apply", 32'h0, 32'(term_apply));
    run(1'b0, 1'b0, 3'h0, 3'h1, 14'h0, 1'b0);
    chk("cmd_valid", 32'h0, 32'(cmd_valid));
    for (n = 0; n < 200 && sref_refresh !== 1'b1; n++)
      @(negedge clk);
    chk("sref_refresh", 32'h1, 32'(sref_refresh));
    for (n = 1; n < 200; n++)
    begin
      @(negedge clk);
      if (sref_refresh === 1'b1)
        break;
    end
    chk("sref_gap", 32'(SREF_INT_CYC), 32'(n));
    u_dcil_ctrl_model.level(1'b1, 1'b1);
    wait_ps(PS_RUN);
    chk("clk_buf_en", 32'h1, 32'(clk_buf_en));
    $display("test self-refresh done");
    finish_test();
  end
endmodule
